// ### bench/flash_host_tb.sv
// Purpose: Self-checking bench for the flash host controller
// Assumes: 20 MHz clock; erase pulse shortened to keep the run brief
// Notes: Inputs change at the falling edge only
`timescale 1ns/100ps
`include "flash_host_defines.svh"
module flash_host_tb;
	import flash_host_pkg::*;
	localparam int ERASE_N = 300;
	logic clock, rst_n, req_valid, req_ready, done, ce_n, oe_n, we_n;
	logic vpp_on, d_oe;
	req_t req;
	logic [7:0] rdata, d_o, d_i, wr_cnt, lat_d, prev_d, clash, c0;
	logic [14:0] addr, lat_a;
	realtime wr_time;
	int fails, n_tests, n, p;

	flash_host #(.ERASE_CYC(ERASE_N)) dut_u (.clock(clock), .rst_n(rst_n),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.done(done), .rdata(rdata), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.vpp_on(vpp_on), .byte_address_lines(addr),
		.byte_data_lines_o(d_o), .byte_data_lines_oe(d_oe),
		.byte_data_lines_i(d_i));
	flash_model mem_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.vpp_on(vpp_on), .addr(addr), .din(d_o), .din_oe(d_oe), .q(d_i),
		.wr_cnt(wr_cnt), .lat_a(lat_a), .lat_d(lat_d), .prev_d(prev_d),
		.wr_time(wr_time), .clash(clash));

	// ==========================================================
	// Shared tasks
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	// One request; n counts cycles from the taking edge to done
	task automatic run_op(input op_t op, input logic [14:0] a,
		input logic [7:0] c, input logic [7:0] d);
		@(negedge clock);
		c0 = wr_cnt;
		req_valid = 1'b1;
		req = '{op: op, addr: a, cmd: c, data: d};
		@(negedge clock);
		req_valid = 1'b0;
		n = 1;
		while (done !== 1'b1 && n < 2000) begin
			@(negedge clock);
			n++;
		end
		p = int'(($realtime - wr_time) / 50.0);
		if (n >= 2000) begin
			fails++;
			wrap_up();
		end
	endtask : run_op

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk("idle pins", {ce_n, oe_n, we_n, vpp_on, d_oe}, 5'h1C);
		chk("ready", {req_ready, done}, 2'h2);
		$display("test reset done");
	endtask : t_reset
	task automatic t_write();
		run_op(OP_WRITE, 15'h1234, 8'h40, 8'h00);
		chk("write cycles", n, 5);
		chk("write count", wr_cnt, c0 + 8'h01);
		chk("write addr", lat_a, 15'h1234);
		chk("write data", lat_d, 8'h40);
		$display("test write done");
	endtask : t_write
	task automatic t_prog();
		run_op(OP_PROG, 15'h7FFF, 8'h40, 8'h3C);
		chk("prog count", wr_cnt, c0 + 8'h02);
		chk("prog bytes", {prev_d, lat_d}, 16'h403C);
		chk("prog addr", lat_a, 15'h7FFF);
		chk("prog pulse", p >= 200 && p <= 210, 1);
		chk("supply off", vpp_on, 1'b0);
		$display("test program done");
	endtask : t_prog
	task automatic t_erase();
		run_op(OP_ERASE, 15'h0000, 8'h20, 8'h00);
		chk("erase count", wr_cnt, c0 + 8'h02);
		chk("erase bytes", {prev_d, lat_d}, 16'h2020);
		chk("erase pulse", p >= ERASE_N && p <= ERASE_N + 10, 1);
		$display("test erase done");
	endtask : t_erase
	task automatic t_read();
		// Issued one idle cycle after the erase finished
		run_op(OP_READ, 15'h7FFF, 8'h00, 8'h00);
		chk("read cycles", n, 7);
		chk("read byte", rdata, 8'h5A);
		chk("read no write", wr_cnt, c0);
		run_op(OP_READ, 15'h0000, 8'h00, 8'h00);
		chk("read low", rdata, 8'hA5);
		chk("no clash", clash, 8'h00);
		$display("test read done");
	endtask : t_read

	// ==========================================================
	// Clock and main sequence
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		fails = 0;
		n_tests = 0;
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		repeat (5) @(negedge clock);
		t_reset();
		rst_n = 1'b1;
		t_write();
		t_prog();
		t_erase();
		t_read();
		wrap_up();
	end
endmodule : flash_host_tb

// ### bench/flash_model.sv
// Purpose: Behavioural byte-wide flash facing the host controller
// Assumes: Host drives all control pins; bench resolves the data pins
// Notes: Array reads return a fixed pattern of the address
`timescale 1ns/100ps
module flash_model (
	// Control pins
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic vpp_on,
	// Address and data pins
	input wire logic [14:0] addr,
	input wire logic [7:0] din,
	input wire logic din_oe,
	output logic [7:0] q,
	// Observation for the bench
	output logic [7:0] wr_cnt,
	output logic [14:0] lat_a,
	output logic [7:0] lat_d,
	output logic [7:0] prev_d,
	output realtime wr_time,
	output logic [7:0] clash
);
	logic [14:0] a_hold;
	logic [7:0] last;
	logic wr_act;

	initial begin
		wr_cnt = 8'h00;
		clash = 8'h00;
		last = 8'h00;
		q = 8'hFF;
	end
	// ==========================================================
	// Write path: output gate low inhibits writing
	assign wr_act = !ce_n && !we_n && oe_n;
	// Address taken at the later falling strobe
	always @(negedge we_n or negedge ce_n) begin
		if (!we_n && !ce_n) a_hold <= addr;
	end
	// Data taken at the first rising strobe, only with high supply
	always @(negedge wr_act) begin
		if (vpp_on) begin
			prev_d <= lat_d;
			lat_d <= din_oe ? din : ~din;
			lat_a <= a_hold;
			wr_cnt <= wr_cnt + 8'h01;
			wr_time <= $realtime;
		end
	end
	// ==========================================================
	// Read path; released lines show the inverse of the last byte
	always @(ce_n or oe_n or addr) begin
		if (!ce_n && !oe_n) begin
			q = addr[7:0] ^ 8'hA5;
			last = q;
		end else begin
			q = ~last;
		end
	end
	// Host driving data while our outputs are on is a clash
	always @(posedge din_oe or negedge oe_n) begin
		if (din_oe && !oe_n && !ce_n) clash <= clash + 8'h01;
	end
endmodule : flash_model

// ### rtl/flash_host.sv
// Purpose: Host controller driving a bulk-erase byte-wide flash by its pins
// Assumes: One 20 MHz clock, synchronous active-low reset
// Notes: Command codes come from the user; the host only sequences pins
// Operation
// RULE_01: 32K bytes, eight data lines, fifteen address lines
// RULE_02: Address latched at later falling strobe
// RULE_03: Data latched at first rising strobe
// RULE_04: Device latches address and data internally
// RULE_05: Command register feeds internal state machine
// RULE_06: Command writes need high programming supply
// RULE_07: Without high supply, reads by pins only
// RULE_08: Erase and program need two writes
// RULE_09: High supply adds modes by command
// RULE_10: Chip-select high means standby
// RULE_11: Outputs driven only while output gate low
// RULE_12: Host keeps output gate high while writing
// RULE_13: Write strobe high means no write
// RULE_14: Host times program pulse at 10 us
// RULE_15: Whole-array erase; host times 10 ms
// RULE_16: Device stop timer ends long pulses
// RULE_17: One byte per program; erase all bits
// RULE_18: Device floats data when not reading
`timescale 1ns/100ps
`include "flash_host_defines.svh"

module flash_host
	import flash_host_pkg::*;
#(
	parameter int ERASE_CYC = `FH_ERASE_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// User request port
	input wire logic req_valid,
	input wire req_t req,
	output logic req_ready,
	output logic done,
	output logic [`FH_DATA_W-1:0] rdata,
	// Flash pins
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic vpp_on,
	output logic [`FH_ADDR_W-1:0] byte_address_lines,
	output logic [`FH_DATA_W-1:0] byte_data_lines_o,
	output logic byte_data_lines_oe,
	input wire logic [`FH_DATA_W-1:0] byte_data_lines_i
);

	localparam logic [`FH_CNT_W-1:0] SETUP_LD = `FH_CNT_W'(`FH_SETUP_CYC - 1);
	localparam logic [`FH_CNT_W-1:0] WE_LD = `FH_CNT_W'(`FH_WE_CYC - 1);
	localparam logic [`FH_CNT_W-1:0] HOLD_LD = `FH_CNT_W'(`FH_HOLD_CYC - 1);
	localparam logic [`FH_CNT_W-1:0] RD_LD = `FH_CNT_W'(`FH_RD_CYC - 1);
	localparam logic [`FH_CNT_W-1:0] PROG_LD = `FH_CNT_W'(`FH_PROG_CYC - 1);
	localparam logic [`FH_CNT_W-1:0] ERASE_LD = `FH_CNT_W'(ERASE_CYC - 1);
	localparam logic [`FH_CNT_W-1:0] CNT_ZERO = `FH_CNT_W'(0);

	// Idle pins: deselected, outputs gated off, no write, supply low
	localparam pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
		vpp_on: 1'b0, addr: '0, data_o: '0, data_oe: 1'b0};
	localparam ctl_t CTL_RESET = '{st: ST_IDLE, op: OP_READ, cnt: '0,
		second: 1'b0, byte2: '0, sync1: '0, sync2: '0, rdata: '0,
		done: 1'b0, pins: PINS_IDLE};

	ctl_t ctl_reg;
	ctl_t ctl_next;

	// ======================================================
	// Next-state logic
	// Pins are decoded from the next state so that every pin is a
	// flip-flop output and cannot glitch on the flash strobes.
	always_comb begin
		ctl_next = ctl_reg;
		ctl_next.done = 1'b0;
		// Two-stage synchroniser on the data pins
		ctl_next.sync1 = byte_data_lines_i;
		ctl_next.sync2 = ctl_reg.sync1;
		if (ctl_reg.cnt != CNT_ZERO) begin
			ctl_next.cnt = ctl_reg.cnt - `FH_CNT_W'(1);
		end
		unique case (ctl_reg.st)
			ST_IDLE: begin
				if (req_valid) begin
					ctl_next.op = req.op;
					ctl_next.pins.addr = req.addr;
					ctl_next.pins.data_o = req.cmd;
					// Program writes the data byte second; erase repeats the command
					ctl_next.second = (req.op == OP_PROG) || (req.op == OP_ERASE); // RULE_08
					ctl_next.byte2 = (req.op == OP_PROG) ? req.data : req.cmd;
					if (req.op == OP_READ) begin
						ctl_next.st = ST_READ;
						ctl_next.cnt = RD_LD;
					end else begin
						ctl_next.st = ST_SETUP;
						ctl_next.cnt = SETUP_LD;
					end
				end
			end
			ST_SETUP: begin
				if (ctl_reg.cnt == CNT_ZERO) begin
					ctl_next.st = ST_STROBE;
					ctl_next.cnt = WE_LD;
				end
			end
			ST_STROBE: begin
				if (ctl_reg.cnt == CNT_ZERO) begin
					ctl_next.st = ST_HOLD;
					ctl_next.cnt = HOLD_LD;
				end
			end
			ST_HOLD: begin
				if (ctl_reg.cnt == CNT_ZERO) begin
					if (ctl_reg.second) begin
						// Second cycle of a two-cycle command
						ctl_next.second = 1'b0; // RULE_08
						ctl_next.pins.data_o = ctl_reg.byte2;
						ctl_next.st = ST_SETUP;
						ctl_next.cnt = SETUP_LD;
					end else if (ctl_reg.op == OP_WRITE) begin
						ctl_next.st = ST_IDLE;
						ctl_next.done = 1'b1;
					end else begin
						// Host times the pulse; device stop timer is a backstop only
						ctl_next.st = ST_PULSE;
						ctl_next.cnt = (ctl_reg.op == OP_PROG) ? PROG_LD
							: ERASE_LD; // RULE_14 RULE_15
					end
				end
			end
			ST_READ: begin
				if (ctl_reg.cnt == CNT_ZERO) begin
					// Access time plus synchroniser latency has passed
					ctl_next.rdata = ctl_reg.sync2; // RULE_11
					ctl_next.st = ST_IDLE;
					ctl_next.done = 1'b1;
				end
			end
			ST_PULSE: begin
				if (ctl_reg.cnt == CNT_ZERO) begin
					ctl_next.st = ST_IDLE;
					ctl_next.done = 1'b1;
				end
			end
		endcase
		// Pin decode from the next state
		ctl_next.pins.ce_n = !(ctl_next.st inside {ST_SETUP, ST_STROBE,
			ST_READ}); // RULE_10
		ctl_next.pins.we_n = (ctl_next.st != ST_STROBE); // RULE_13
		ctl_next.pins.oe_n = (ctl_next.st != ST_READ); // RULE_12
		// Data held one cycle past the rising strobes
		ctl_next.pins.data_oe = ctl_next.st inside {ST_SETUP, ST_STROBE,
			ST_HOLD}; // RULE_03
		// Supply raised for the whole of any write-type operation
		ctl_next.pins.vpp_on = (ctl_next.st != ST_IDLE)
			&& (ctl_next.op != OP_READ); // RULE_06 RULE_07
	end

	// ======================================================
	// State register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctl_reg <= CTL_RESET;
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	// ======================================================
	// Outputs
	assign req_ready = (ctl_reg.st == ST_IDLE);
	assign done = ctl_reg.done;
	assign rdata = ctl_reg.rdata;
	assign ce_n = ctl_reg.pins.ce_n;
	assign oe_n = ctl_reg.pins.oe_n;
	assign we_n = ctl_reg.pins.we_n;
	assign vpp_on = ctl_reg.pins.vpp_on;
	assign byte_address_lines = ctl_reg.pins.addr;
	assign byte_data_lines_o = ctl_reg.pins.data_o;
	assign byte_data_lines_oe = ctl_reg.pins.data_oe;

	// ======================================================
	// Assertion helpers: strobe count and pulse length
	logic [1:0] wr_cnt;
	logic [`FH_CNT_W-1:0] pulse_len;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_cnt <= 2'h0;
			pulse_len <= '0;
		end else begin
			if (ctl_reg.st == ST_IDLE) begin
				wr_cnt <= 2'h0;
			end else if (ctl_reg.st == ST_SETUP && ctl_next.st == ST_STROBE) begin
				wr_cnt <= wr_cnt + 2'h1;
			end
			pulse_len <= (ctl_reg.st == ST_PULSE) ? pulse_len + `FH_CNT_W'(1)
				: '0;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_we_gate_high: assert property (!we_n |-> oe_n) // RULE_12
		else $error("write strobe low with output gate low");
	a_drive_gate_off: assert property (byte_data_lines_oe |-> oe_n) // RULE_18
		else $error("host drives data while output gate low");
	a_write_supply: assert property (!we_n |-> vpp_on && !ce_n) // RULE_06
		else $error("write strobe without supply or select");
	a_idle_standby: assert property (req_ready |-> ce_n && we_n) // RULE_10
		else $error("idle host not in standby");
	a_we_width: assert property ($fell(we_n) |->
		!we_n ##1 !we_n ##1 we_n) // RULE_13
		else $error("write strobe width not two cycles");
	a_addr_stable: assert property (!ce_n && !we_n |->
		$stable(byte_address_lines)) // RULE_02
		else $error("address moved during write strobe");
	a_data_hold: assert property ($rose(we_n) |->
		byte_data_lines_oe && $stable(byte_data_lines_o)) // RULE_03
		else $error("data not held at rising strobe");
	a_two_writes: assert property ($rose(ctl_reg.st == ST_PULSE) |->
		wr_cnt == 2'h2) // RULE_08
		else $error("pulse started without two writes");
	a_prog_time: assert property ($rose(ctl_reg.st == ST_PULSE)
		&& ctl_reg.op == OP_PROG |-> ##199 (ctl_reg.st == ST_PULSE)
		##1 done) // RULE_14
		else $error("program pulse not 200 cycles");
	a_erase_time: assert property ($fell(ctl_reg.st == ST_PULSE)
		&& ctl_reg.op == OP_ERASE |->
		pulse_len == `FH_CNT_W'(ERASE_CYC)) // RULE_15
		else $error("erase pulse length wrong");
	a_read_gate: assert property (!oe_n |-> !byte_data_lines_oe && !vpp_on
		&& we_n) // RULE_07
		else $error("read with drive, supply or strobe");

	c_prog_done: cover property (done && ctl_reg.op == OP_PROG);
	c_erase_done: cover property (done && ctl_reg.op == OP_ERASE);
	c_read_done: cover property (done && ctl_reg.op == OP_READ);
	c_write_done: cover property (done && ctl_reg.op == OP_WRITE);

endmodule : flash_host

// ### rtl/flash_host_defines.svh
// Purpose: Timing and width constants for the flash host controller
// Assumes: 20 MHz system clock
// Notes: Cycle counts derive from times; least times round up
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

// ==========================================================
// Pin widths
`define FH_ADDR_W 15
`define FH_DATA_W 8

// ==========================================================
// Times in their own units
`define FH_CLK_NS 50
`define FH_SETUP_NS 50
`define FH_WE_NS 100
`define FH_HOLD_NS 50
`define FH_ACC_NS 200
`define FH_SYNC_STAGES 2
`define FH_PROG_US 10
`define FH_ERASE_MS 10

// ==========================================================
// Derived cycle counts (least times, rounded up)
`define FH_CEIL(ns) (((ns) + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_SETUP_CYC `FH_CEIL(`FH_SETUP_NS)
`define FH_WE_CYC `FH_CEIL(`FH_WE_NS)
`define FH_HOLD_CYC `FH_CEIL(`FH_HOLD_NS)
`define FH_RD_CYC (`FH_CEIL(`FH_ACC_NS) + `FH_SYNC_STAGES)
`define FH_PROG_CYC `FH_CEIL(`FH_PROG_US * 1000)
`define FH_ERASE_CYC `FH_CEIL(`FH_ERASE_MS * 1000000)
`define FH_CNT_W 18

`endif

// ### rtl/flash_host_pkg.sv
// Purpose: Types shared by the flash host controller
// Assumes: Constants come from the defines header
// Notes: One-hot state codes are written out
`include "flash_host_defines.svh"

package flash_host_pkg;

	// ======================================================
	// Operations the user may request
	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_WRITE = 2'h1,
		OP_PROG = 2'h2,
		OP_ERASE = 2'h3
	} op_t;

	// ======================================================
	// Bus sequencer states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SETUP = 6'h02,
		ST_STROBE = 6'h04,
		ST_HOLD = 6'h08,
		ST_READ = 6'h10,
		ST_PULSE = 6'h20
	} state_t;

	// User request
	typedef struct packed {
		op_t op;
		logic [`FH_ADDR_W-1:0] addr;
		logic [`FH_DATA_W-1:0] cmd;
		logic [`FH_DATA_W-1:0] data;
	} req_t;

	// Flash pins driven by the host
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic vpp_on;
		logic [`FH_ADDR_W-1:0] addr;
		logic [`FH_DATA_W-1:0] data_o;
		logic data_oe;
	} pins_t;

	// Whole controller state
	typedef struct packed {
		state_t st;
		op_t op;
		logic [`FH_CNT_W-1:0] cnt;
		logic second;
		logic [`FH_DATA_W-1:0] byte2;
		logic [`FH_DATA_W-1:0] sync1;
		logic [`FH_DATA_W-1:0] sync2;
		logic [`FH_DATA_W-1:0] rdata;
		logic done;
		pins_t pins;
	} ctl_t;

endpackage : flash_host_pkg
